// file: esfm_pkg.sv
// Purpose: constants and carriers for the encoder and scale fault monitor
// Assumes: one clock, synchronous active-low reset
// Notes: alarm codes are main/sub pairs as shown on the driver display
package esfm_pkg;
	localparam int ESFM_NUM_ALM = 16;
	localparam int ESFM_SCALE_BITS = 6;
	localparam logic [3:0] ESFM_SETUP_IGNORE_OVF = 4'h2;
	localparam logic [15:0] ESFM_TURN_LIMIT = 16'h7FFF;
	localparam logic [7:0] ESFM_MISS_LIMIT_RST = 8'h03;
	// alarm slot indices, also the priority order (lowest index wins)
	localparam int ESFM_I40 = 0;
	localparam int ESFM_I41 = 1;
	localparam int ESFM_I42 = 2;
	localparam int ESFM_I43 = 3;
	localparam int ESFM_I44 = 4;
	localparam int ESFM_I45 = 5;
	localparam int ESFM_I47 = 6;
	localparam int ESFM_I48 = 7;
	localparam int ESFM_I49 = 8;
	localparam int ESFM_I50_0 = 9;
	localparam int ESFM_I50_1 = 10;
	localparam int ESFM_I51 = 11;
	localparam logic [7:0] ESFM_MAIN_40 = 8'h28;
	localparam logic [7:0] ESFM_MAIN_41 = 8'h29;
	localparam logic [7:0] ESFM_MAIN_42 = 8'h2A;
	localparam logic [7:0] ESFM_MAIN_43 = 8'h2B;
	localparam logic [7:0] ESFM_MAIN_44 = 8'h2C;
	localparam logic [7:0] ESFM_MAIN_45 = 8'h2D;
	localparam logic [7:0] ESFM_MAIN_47 = 8'h2F;
	localparam logic [7:0] ESFM_MAIN_48 = 8'h30;
	localparam logic [7:0] ESFM_MAIN_49 = 8'h31;
	localparam logic [7:0] ESFM_MAIN_50 = 8'h32;
	localparam logic [7:0] ESFM_MAIN_51 = 8'h33;
	localparam logic [7:0] ESFM_MAIN_NONE = 8'h00;

	typedef struct packed {
		logic backup_cap_low;
		logic battery_overspeed;
		logic init_fail;
		logic single_turn_fault;
		logic multi_turn_fault;
		logic powerup_overspeed;
		logic index_missing;
		logic commutation_illegal;
		logic encoder_reset;
	} esfm_enc_t;

	typedef struct packed {
		logic frame_ok;
		logic frame_absent;
		logic frame_crc_err;
		logic [5:0] scale_fault_word;
	} esfm_scale_t;

	typedef struct packed {
		logic active;
		logic [7:0] main_code;
		logic [7:0] sub_code;
	} esfm_alarm_t;
endpackage : esfm_pkg

// file: esfm_monitor.sv
// Purpose: latches encoder and external scale faults as main/sub alarm codes
// Assumes: fault inputs are asynchronous levels or pulses from pins
// Notes: all inputs but rst_n_in pass a two-stage synchroniser before any logic reads them
`timescale 1ns/1ps
module esfm_monitor import esfm_pkg::*; #(
	parameter logic [7:0] MISS_LIMIT = ESFM_MISS_LIMIT_RST
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// encoder status
	input wire esfm_enc_t enc_in,
	input wire logic [15:0] multi_turn_count_in,
	input wire logic [3:0] absolute_encoder_setup_param_in,
	// external scale status
	input wire esfm_scale_t scale_in,
	// host
	input wire logic alarm_clear_input_in,
	// alarm report
	output esfm_alarm_t alarm_out,
	output logic [11:0] alarm_pending_out
);
	localparam int EW = $bits(esfm_enc_t);
	localparam int SW = $bits(esfm_scale_t);

	logic [EW-1:0] enc_s1, enc_s2;
	logic [SW-1:0] scl_s1, scl_s2;
	logic [15:0] turn_s1, turn_s2;
	logic [15:0] turn_prev;
	logic [3:0] setup_s1, setup_s2;
	logic clr_s1, clr_s2, clr_prev;
	logic [5:0] word_prev;
	logic [7:0] miss_cnt;
	logic [11:0] latched;
	logic [5:0] sub51;
	logic enc_reset_seen;
	logic [EW-1:0] next_enc_s1, next_enc_s2;
	logic [SW-1:0] next_scl_s1, next_scl_s2;
	logic [15:0] next_turn_s1, next_turn_s2;
	logic [15:0] next_turn_prev;
	logic [3:0] next_setup_s1, next_setup_s2;
	logic next_clr_s1, next_clr_s2, next_clr_prev;
	logic [5:0] next_word_prev;
	logic [7:0] next_miss_cnt;
	logic [11:0] next_latched;
	logic [5:0] next_sub51;
	logic next_enc_reset_seen;
	esfm_alarm_t next_alarm;
	esfm_enc_t enc;
	esfm_scale_t scl;
	logic [11:0] raise;
	logic clr_pulse;

	// decoded view of the second synchroniser stage
	assign enc = esfm_enc_t'(enc_s2);
	assign scl = esfm_scale_t'(scl_s2);
	// only a rising clear request acts; a held level does nothing
	assign clr_pulse = clr_s2 & ~clr_prev;

	// synchronisers: pins pass two flops before any logic reads them
	always_comb begin
		next_enc_s1 = enc_in;
		next_enc_s2 = enc_s1;
		next_scl_s1 = scale_in;
		next_scl_s2 = scl_s1;
		next_turn_s1 = multi_turn_count_in;
		next_turn_s2 = turn_s1;
		next_setup_s1 = absolute_encoder_setup_param_in;
		next_setup_s2 = setup_s1;
		next_clr_s1 = alarm_clear_input_in;
		next_clr_s2 = clr_s1;
		// the count word is only trusted once two samples agree
		next_turn_prev = turn_s2;
	end

	// setup word is quasi-static, so a plain two-flop pass is enough
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			enc_s1 <= '0;
			enc_s2 <= '0;
			scl_s1 <= '0;
			scl_s2 <= '0;
			turn_s1 <= '0;
			turn_s2 <= '0;
			turn_prev <= '0;
			setup_s1 <= '0;
			setup_s2 <= '0;
			clr_s1 <= 1'b0;
			clr_s2 <= 1'b0;
		end else begin
			enc_s1 <= next_enc_s1;
			enc_s2 <= next_enc_s2;
			scl_s1 <= next_scl_s1;
			scl_s2 <= next_scl_s2;
			turn_s1 <= next_turn_s1;
			turn_s2 <= next_turn_s2;
			turn_prev <= next_turn_prev;
			setup_s1 <= next_setup_s1;
			setup_s2 <= next_setup_s2;
			clr_s1 <= next_clr_s1;
			clr_s2 <= next_clr_s2;
		end
	end

	// scale link loss: consecutive absent samples, a good frame restarts
	always_comb begin
		// saturates at the limit so a long outage cannot wrap back to zero
		next_miss_cnt = miss_cnt;
		if (scl.frame_ok) begin
			next_miss_cnt = 8'h00;
		end else if (scl.frame_absent && miss_cnt != MISS_LIMIT) begin
			next_miss_cnt = miss_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			miss_cnt <= '0;
		end else begin
			miss_cnt <= next_miss_cnt;
		end
	end

	// alarm latch, clear qualification and scale status edges
	always_comb begin
		next_clr_prev = clr_s2;
		next_word_prev = scl.scale_fault_word;
		raise = '0;
		raise[ESFM_I40] = enc.backup_cap_low;
		// overflow is simply not evaluated when suppressed
		// count bits may land on different edges; a torn word must not alarm
		raise[ESFM_I41] = (turn_s2 > ESFM_TURN_LIMIT) && (turn_s2 == turn_prev) &&
			(setup_s2 != ESFM_SETUP_IGNORE_OVF);
		raise[ESFM_I42] = enc.battery_overspeed;
		raise[ESFM_I43] = enc.init_fail;
		raise[ESFM_I44] = enc.single_turn_fault;
		raise[ESFM_I45] = enc.multi_turn_fault;
		raise[ESFM_I47] = enc.powerup_overspeed;
		raise[ESFM_I48] = enc.index_missing;
		raise[ESFM_I49] = enc.commutation_illegal;
		raise[ESFM_I50_0] = (miss_cnt == MISS_LIMIT);
		raise[ESFM_I50_1] = scl.frame_crc_err;
		raise[ESFM_I51] = |(scl.scale_fault_word & ~word_prev);
		next_sub51 = sub51 | (scl.scale_fault_word & ~word_prev);
		// encoder reset arms a clear of 40/42 only
		next_enc_reset_seen = enc_reset_seen | enc.encoder_reset;
		next_latched = latched | raise;
		if (clr_pulse && enc_reset_seen) begin
			// set wins over clear: a still-present cause re-latches
			next_latched[ESFM_I40] = raise[ESFM_I40];
			next_latched[ESFM_I42] = raise[ESFM_I42];
			next_enc_reset_seen = enc.encoder_reset;
		end
		// remaining slots have no clear path but reset
	end

	// alarm state survives everything but reset (standing in for a power cycle) and the armed clear of 40/42
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			clr_prev <= 1'b0;
			word_prev <= '0;
			latched <= '0;
			sub51 <= '0;
			enc_reset_seen <= 1'b0;
		end else begin
			clr_prev <= next_clr_prev;
			word_prev <= next_word_prev;
			latched <= next_latched;
			sub51 <= next_sub51;
			enc_reset_seen <= next_enc_reset_seen;
		end
	end

	// report: lowest slot wins, alarm 51 shows its lowest latched bit
	always_comb begin
		// lowest index is scanned last so that it overrides the others
		next_alarm.active = |latched;
		next_alarm.main_code = ESFM_MAIN_NONE;
		next_alarm.sub_code = 8'h00;
		for (int i = ESFM_NUM_ALM - 5; i >= 0; i--) begin
			if (latched[i]) begin
				next_alarm.sub_code = 8'h00;
				case (i)
					ESFM_I40: next_alarm.main_code = ESFM_MAIN_40;
					ESFM_I41: next_alarm.main_code = ESFM_MAIN_41;
					ESFM_I42: next_alarm.main_code = ESFM_MAIN_42;
					ESFM_I43: next_alarm.main_code = ESFM_MAIN_43;
					ESFM_I44: next_alarm.main_code = ESFM_MAIN_44;
					ESFM_I45: next_alarm.main_code = ESFM_MAIN_45;
					ESFM_I47: next_alarm.main_code = ESFM_MAIN_47;
					ESFM_I48: next_alarm.main_code = ESFM_MAIN_48;
					ESFM_I49: next_alarm.main_code = ESFM_MAIN_49;
					ESFM_I50_0: next_alarm.main_code = ESFM_MAIN_50;
					ESFM_I50_1: begin
						next_alarm.main_code = ESFM_MAIN_50;
						next_alarm.sub_code = 8'h01;
					end
					default: begin
						next_alarm.main_code = ESFM_MAIN_51;
						for (int b = ESFM_SCALE_BITS - 1; b >= 0; b--) begin
							if (sub51[b]) begin
								next_alarm.sub_code = 8'(b);
							end
						end
					end
				endcase
			end
		end
	end

	// registered so the display never shows a half-updated code pair
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			alarm_out <= '0;
		end else begin
			alarm_out <= next_alarm;
		end
	end

	assign alarm_pending_out = latched;
endmodule : esfm_monitor

// file: esfm_monitor_asserts.sv
// Purpose: port checks on the fault monitor
// Assumes: three edges from a pin change to a latched alarm, four for 41; 50/0 latches three edges after the pin absent run reaches the limit
// Notes: bound into every monitor instance
`timescale 1ns/1ps
module esfm_monitor_asserts import esfm_pkg::*; #(
	parameter logic [7:0] MISS_LIMIT = ESFM_MISS_LIMIT_RST
) (
	// monitor ports
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire esfm_enc_t enc_in,
	input wire logic [15:0] multi_turn_count_in,
	input wire logic [3:0] absolute_encoder_setup_param_in,
	input wire esfm_scale_t scale_in,
	input wire logic alarm_clear_input_in,
	input wire esfm_alarm_t alarm_out,
	input wire logic [11:0] alarm_pending_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_hit40;
		##[1:4] alarm_pending_out[ESFM_I40] ##1 alarm_out.main_code == ESFM_MAIN_40;
	endsequence
	property p_cap; enc_in.backup_cap_low |-> s_hit40; endproperty
	a_cap: assert property (p_cap) else $error("cap loss missed");
	property p_ovf; (multi_turn_count_in > ESFM_TURN_LIMIT &&
		absolute_encoder_setup_param_in != ESFM_SETUP_IGNORE_OVF)[*5] |-> alarm_pending_out[ESFM_I41];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");
	// a 41 seen now must already have stood before suppression reached the latch
	property p_ign; (absolute_encoder_setup_param_in == ESFM_SETUP_IGNORE_OVF)[*5]
		|-> !alarm_pending_out[ESFM_I41] || $past(alarm_pending_out[ESFM_I41], 2);
	endproperty
	a_ign: assert property (p_ign) else $error("overflow not ignored");
	property p_init; enc_in.init_fail |-> ##[1:4] alarm_pending_out[ESFM_I43]; endproperty
	a_init: assert property (p_init) else $error("init fault missed");
	property p_crc; scale_in.frame_crc_err |-> ##[1:4] alarm_pending_out[ESFM_I50_1]; endproperty
	a_crc: assert property (p_crc) else $error("scale data fault missed");
	// run of absent scale samples seen at the pins, saturating at the limit
	logic [7:0] absent_run;
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			absent_run <= 8'h00;
		end else if (scale_in.frame_ok) begin
			absent_run <= 8'h00;
		end else if (scale_in.frame_absent && absent_run != MISS_LIMIT) begin
			absent_run <= absent_run + 8'h01;
		end
	end
	property p_miss; absent_run == MISS_LIMIT |-> ##[1:4] alarm_pending_out[ESFM_I50_0];
	endproperty
	a_miss: assert property (p_miss) else $error("scale link loss missed");
	property p_word;
		$rose(|scale_in.scale_fault_word) |-> ##[1:4] alarm_pending_out[ESFM_I51];
	endproperty
	a_word: assert property (p_word) else $error("scale status missed");
	property p_keep; ($past(alarm_pending_out) & ~alarm_pending_out & 12'hFFA) == 12'h000;
	endproperty
	a_keep: assert property (p_keep) else $error("sticky alarm dropped");
	property p_clr; $fell(alarm_pending_out[ESFM_I40]) || $fell(alarm_pending_out[ESFM_I42])
		|-> $past(alarm_clear_input_in, 3) || $past(alarm_clear_input_in, 4); endproperty
	alarm_clear_input: assert property (p_clr) else $error("clear without request");
endmodule : esfm_monitor_asserts
bind esfm_monitor esfm_monitor_asserts #(.MISS_LIMIT(MISS_LIMIT)) esfm_monitor_asserts_i (
	.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .enc_in(enc_in),
	.multi_turn_count_in(multi_turn_count_in), .scale_in(scale_in),
	.absolute_encoder_setup_param_in(absolute_encoder_setup_param_in),
	.alarm_clear_input_in(alarm_clear_input_in), .alarm_out(alarm_out),
	.alarm_pending_out(alarm_pending_out));

// file: esfm_partner.sv
// Purpose: encoder, scale and host as seen by the monitor
// Assumes: tasks called from the bench process
// Notes: frames arrive every cycle unless the link is lost
`timescale 1ns/1ps
module esfm_partner import esfm_pkg::*; (
	// clock
	input wire logic clk_sys_in,
	// fault sources and host
	output esfm_enc_t enc_out = '0,
	output esfm_scale_t scale_out = '0,
	output logic [15:0] turns_out = 16'h0000,
	output logic [3:0] setup_out = 4'h0,
	output logic clear_out = 1'b0
);
	task automatic put(input esfm_enc_t e, input logic [5:0] w, input logic crc,
			input logic ls, input logic [15:0] t, input logic [3:0] s);
		@(posedge clk_sys_in);
		enc_out <= e;
		scale_out <= {!ls, ls, crc, w};
		turns_out <= t;
		setup_out <= s;
	endtask : put
	task automatic clear_seq(input logic with_reset);
		@(posedge clk_sys_in);
		enc_out.encoder_reset <= with_reset;
		repeat (4) @(posedge clk_sys_in);
		enc_out.encoder_reset <= 1'b0;
		clear_out <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		clear_out <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
	endtask : clear_seq
endmodule : esfm_partner

// file: esfm_monitor_bench.sv
// Purpose: self-checking bench for the fault monitor
// Assumes: partner drives every fault input
// Notes: miss limit shortened to 2 samples
`timescale 1ns/1ps
module esfm_monitor_bench import esfm_pkg::*; ();
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic clr;
	logic [15:0] turns;
	logic [3:0] setup;
	logic [11:0] pend;
	esfm_enc_t enc;
	esfm_scale_t scale;
	esfm_alarm_t alarm;
	int num_errors = 0;
	int n_checks = 0;
	logic [7:0] enc_main [1:7] = '{ESFM_MAIN_49, ESFM_MAIN_48, ESFM_MAIN_47, ESFM_MAIN_45,
		ESFM_MAIN_44, ESFM_MAIN_43, ESFM_MAIN_42};
	initial forever #5 clk_sys_in = ~clk_sys_in;
	esfm_partner esfm_partner_i (.clk_sys_in(clk_sys_in), .enc_out(enc), .scale_out(scale),
		.turns_out(turns), .setup_out(setup), .clear_out(clr));
	esfm_monitor #(.MISS_LIMIT(8'h02)) esfm_monitor_i (.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in), .enc_in(enc), .multi_turn_count_in(turns), .scale_in(scale),
		.absolute_encoder_setup_param_in(setup), .alarm_clear_input_in(clr),
		.alarm_out(alarm), .alarm_pending_out(pend));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic restart;
		esfm_partner_i.put('0, '0, '0, '0, '0, '0);
		rst_n_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		#1 chk({alarm, pend}, 29'h0);
	endtask : restart
	task automatic settle;
		int i;
		for (i = 0; i < 20 && pend === 12'h000; i++) @(posedge clk_sys_in);
		if (i == 20) begin
			num_errors++;
			$display("BAD %0t no alarm latched", $time);
			test_done();
		end
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask : settle
	task automatic raise(input esfm_enc_t e, input logic [5:0] w, input logic crc,
			input logic ls, input int slot, input logic [7:0] m, input logic [7:0] s);
		restart();
		esfm_partner_i.put(e, w, crc, ls, '0, '0);
		settle();
		chk(pend, 12'h001 << slot);
		chk(alarm, {1'b1, m, s});
		esfm_partner_i.clear_seq(1'b1);
		#1 chk(pend, 12'h001 << slot);
	endtask : raise
	task automatic t_abs40;
		restart();
		esfm_partner_i.put(9'h100, '0, '0, '0, '0, '0);
		settle();
		chk(alarm, {1'b1, ESFM_MAIN_40, 8'h00});
		esfm_partner_i.put('0, '0, '0, '0, '0, '0);
		esfm_partner_i.clear_seq(1'b0);
		#1 chk(pend, 12'h001);
		esfm_partner_i.clear_seq(1'b1);
		#1 chk({alarm, pend}, 29'h0);
	endtask : t_abs40
	task automatic t_abs42;
		restart();
		esfm_partner_i.put(9'h080, '0, '0, '0, '0, '0);
		settle();
		chk(alarm, {1'b1, ESFM_MAIN_42, 8'h00});
		esfm_partner_i.put('0, '0, '0, '0, '0, '0);
		esfm_partner_i.clear_seq(1'b0);
		#1 chk(pend, 12'h004);
		esfm_partner_i.clear_seq(1'b1);
		#1 chk({alarm, pend}, 29'h0);
	endtask : t_abs42
	task automatic t_turns;
		restart();
		esfm_partner_i.put('0, '0, '0, '0, 16'h7FFF, 4'h0);
		repeat (8) @(posedge clk_sys_in);
		esfm_partner_i.put('0, '0, '0, '0, 16'h8000, ESFM_SETUP_IGNORE_OVF);
		repeat (8) @(posedge clk_sys_in);
		#1 chk(pend, 12'h000);
		esfm_partner_i.put('0, '0, '0, '0, 16'h8000, 4'h0);
		settle();
		chk(alarm, {1'b1, ESFM_MAIN_41, 8'h00});
	endtask : t_turns
	initial begin
		int n;
		t_abs40();
		t_abs42();
		t_turns();
		for (n = 1; n < 8; n++)
			raise(9'h001 << n, '0, '0, '0, 9 - n, enc_main[n], '0);
		raise('0, '0, 1'b1, '0, 10, ESFM_MAIN_50, 8'h01);
		raise('0, '0, '0, 1'b1, 9, ESFM_MAIN_50, 8'h00);
		for (n = 0; n < 6; n++)
			raise('0, 6'h01 << n, '0, '0, 11, ESFM_MAIN_51, 8'(n));
		test_done();
	end
endmodule : esfm_monitor_bench
